// File: core/ssdr_top.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Status and diagnosis readback bank
// ---------------------------------------------------------------
// Functional notes
// - Diagnosis is read in any mode with select field 00 and read-select bit 1.
// - Bit 12 at 1 reads without writing the mode register, at 0 also writes the mode register.
// - Diagnosis bit 11 shows the ground offset being outside threshold.
// - Bits 10..7 give the CAN fault code, with code 1010 never reported.
// - Bits 6..5 give the LIN fault code.
// - Bit 4 is 1 while the aux regulator is healthy, 0 after overload shutdown.
// - Bit 3 is 0 when the CAN regulator is off for overload, else 1.
// - The CAN regulator flag returns to 1 when that regulator is switched on again.
// - Bit 2 latches 0 on MCU supply undervoltage and a diagnosis read sets it back to 1 unless undervoltage is present as the read ends.
// - Bits 1..0 give the CAN transceiver mode.
// - Status bit 1 follows the enable output pin.
// - Status bit 0 is set by power-on reset and cleared on entering Normal mode.
// - The reset cause field is overwritten at each reset event and never cleared.
// - Status is read with select 00 and read-select 0, bit 12 acting the same.
// - With the supply fault enable set, clearing any regulator flag raises an interrupt.
module ssdr_top
    import ssdr_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    // Serial port pins
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_mosi,
    output logic o_miso,
    // Monitored conditions
    input wire logic i_gnd_offset_out,
    input wire logic [3:0] i_can_fault,
    input wire logic [1:0] i_lin_fault,
    input wire logic i_aux_overload_off,
    input wire logic i_canreg_overload_off,
    input wire logic i_canreg_restart,
    input wire logic i_mcu_undervolt,
    input wire logic [1:0] i_can_mode,
    input wire logic i_enable_pin_high,
    input wire logic i_normal_entered,
    input wire logic i_reset_event,
    input wire logic [3:0] i_reset_cause,
    input wire logic i_supply_fault_irq_enable,
    // Outputs
    output logic o_mode_write,
    output logic [11:0] o_mode_data,
    output logic o_supply_fault_irq
);
    // ---------------------------------------------------------------
    // Reset release and pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic [2:0] cs_sync_reg;
    logic [2:0] sck_sync_reg;
    logic [2:0] mosi_sync_reg;
    logic cs_q_reg;
    logic sck_q_reg;
    logic mosi_q_reg;
    wire rst_n = rst_sync_reg[1];

    // Reset released through two flops
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    // Change accepted only when stages two and three agree
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_reg <= 3'h7;
            sck_sync_reg <= 3'h0;
            mosi_sync_reg <= 3'h0;
            cs_q_reg <= 1'b1;
            sck_q_reg <= 1'b0;
            mosi_q_reg <= 1'b0;
        end else if (i_ce) begin
            cs_sync_reg <= {cs_sync_reg[1:0], i_cs_n};
            sck_sync_reg <= {sck_sync_reg[1:0], i_sck};
            mosi_sync_reg <= {mosi_sync_reg[1:0], i_mosi};
            if (cs_sync_reg[1] == cs_sync_reg[2]) cs_q_reg <= cs_sync_reg[2];
            if (sck_sync_reg[1] == sck_sync_reg[2]) sck_q_reg <= sck_sync_reg[2];
            if (mosi_sync_reg[1] == mosi_sync_reg[2]) mosi_q_reg <= mosi_sync_reg[2];
        end
    end

    // ---------------------------------------------------------------
    // Frame shifter
    // ---------------------------------------------------------------
    ssdr_frame_if frm ();

    ssdr_shifter u_shift (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_cs_n(cs_q_reg),
        .i_sck(sck_q_reg),
        .i_mosi(mosi_q_reg),
        .o_miso(o_miso),
        .frm(frm)
    );

    // ---------------------------------------------------------------
    // Frame header decode
    // ---------------------------------------------------------------
    // Header latched at decode time so the frame end sees the same target
    logic sel_diag_reg;
    logic sel_sys_reg;
    wire hdr_sys = (frm.hdr[2:1] == SEL_SYSTEM);
    wire hdr_diag = hdr_sys & frm.hdr[0];
    wire hdr_stat = hdr_sys & ~frm.hdr[0];

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_diag_reg <= 1'b0;
            sel_sys_reg <= 1'b0;
        end else if (i_ce && frm.hdr_valid) begin
            sel_diag_reg <= hdr_diag;
            sel_sys_reg <= hdr_sys;
        end
    end

    wire frame_end = frm.done & sel_sys_reg;
    wire diag_read_end = frm.done & sel_diag_reg;
    // Read-only bit arrives fourth, so it is taken from the whole word at frame end
    wire nowr_bit = frm.rx_word[NOWR_POS];

    // ---------------------------------------------------------------
    // Diagnosis flags
    // ---------------------------------------------------------------
    logic aux_ok_reg;
    logic canreg_ok_reg;
    logic mcu_ok_reg;
    logic ground_offset_flag_reg;
    logic [3:0] can_line_fault_code_reg;
    logic [1:0] lin_line_fault_code_reg;
    logic [1:0] can_mode_reg;
    logic irq_reg;

    // Reserved CAN code masked to no failure
    wire [3:0] can_code_clean = (i_can_fault == CANF_RESERVED) ? CANF_NONE : i_can_fault;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            ground_offset_flag_reg <= 1'b0;
            can_line_fault_code_reg <= CANF_NONE;
            lin_line_fault_code_reg <= 2'h0;
            can_mode_reg <= 2'h0;
        end else if (i_ce) begin
            ground_offset_flag_reg <= i_gnd_offset_out;
            can_line_fault_code_reg <= can_code_clean;
            lin_line_fault_code_reg <= i_lin_fault;
            can_mode_reg <= i_can_mode;
        end
    end

    // Regulator flags; a failure on the same cycle as a read wins
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            aux_ok_reg <= 1'b1;
            canreg_ok_reg <= 1'b1;
            mcu_ok_reg <= 1'b1;
        end else if (i_ce) begin
            aux_ok_reg <= ~i_aux_overload_off;
            if (i_canreg_overload_off) begin
                canreg_ok_reg <= 1'b0;
            end else if (i_canreg_restart) begin
                canreg_ok_reg <= 1'b1;
            end
            if (i_mcu_undervolt) begin
                mcu_ok_reg <= 1'b0;
            end else if (diag_read_end) begin
                mcu_ok_reg <= 1'b1;
            end
        end
    end

    // Any regulator flag falling raises the interrupt for one cycle
    wire aux_fall = aux_ok_reg & i_aux_overload_off;
    wire can_fall = canreg_ok_reg & i_canreg_overload_off;
    wire mcu_fall = mcu_ok_reg & i_mcu_undervolt;
    wire flag_fall = aux_fall | can_fall | mcu_fall;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else if (i_ce) begin
            irq_reg <= flag_fall & i_supply_fault_irq_enable;
        end
    end
    assign o_supply_fault_irq = irq_reg;

    // ---------------------------------------------------------------
    // Status fields
    // ---------------------------------------------------------------
    logic enable_pin_state_flag_reg;
    logic power_up_reset_flag_reg;
    logic [3:0] reset_cause_field_reg;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            enable_pin_state_flag_reg <= 1'b0;
            power_up_reset_flag_reg <= 1'b1;
            reset_cause_field_reg <= RSRC_POR;
        end else if (i_ce) begin
            enable_pin_state_flag_reg <= i_enable_pin_high;
            if (i_normal_entered) begin
                power_up_reset_flag_reg <= 1'b0;
            end
            if (i_reset_event) begin
                reset_cause_field_reg <= i_reset_cause;
            end
        end
    end

    // ---------------------------------------------------------------
    // Reply word selection
    // ---------------------------------------------------------------
    wire [15:0] diag_word = {frm.hdr, 1'b0, ground_offset_flag_reg, can_line_fault_code_reg,
        lin_line_fault_code_reg, aux_ok_reg, canreg_ok_reg, mcu_ok_reg, can_mode_reg};
    // Status bits 7..2 belong to other logic and read as zero here
    wire [15:0] stat_word = {frm.hdr, 1'b0, reset_cause_field_reg, 6'h00,
        enable_pin_state_flag_reg, power_up_reset_flag_reg};
    assign frm.tx_word = hdr_diag ? diag_word : (hdr_stat ? stat_word : WORD_ZERO);

    // ---------------------------------------------------------------
    // Mode register write request
    // ---------------------------------------------------------------
    logic mode_write_reg;
    logic [11:0] mode_data_reg;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_write_reg <= 1'b0;
            mode_data_reg <= MODE_ZERO;
        end else if (i_ce) begin
            mode_write_reg <= frame_end & ~nowr_bit;
            if (frame_end && !nowr_bit) begin
                mode_data_reg <= frm.rx_word[11:0];
            end
        end
    end
    assign o_mode_write = mode_write_reg;
    assign o_mode_data = mode_data_reg;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence s_undervolt;
        i_ce && i_mcu_undervolt;
    endsequence

    chk_mcu_latch: assert property (@(posedge i_mclk) disable iff (!rst_n)
        s_undervolt |=> !mcu_ok_reg)
        else $error("mcu flag not latched low");
    chk_mcu_rearm: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && diag_read_end && !i_mcu_undervolt) |=> mcu_ok_reg)
        else $error("mcu flag not set by read");
    chk_can_reserved: assert property (@(posedge i_mclk) disable iff (!rst_n)
        can_line_fault_code_reg != CANF_RESERVED)
        else $error("reserved can code reported");
    chk_canreg_off: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && i_canreg_overload_off) |=> !canreg_ok_reg)
        else $error("can regulator flag not cleared");
    chk_canreg_on: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && i_canreg_restart && !i_canreg_overload_off) |=> canreg_ok_reg)
        else $error("can regulator flag not restored");
    chk_mode_nowrite: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && frame_end && nowr_bit) |=> !o_mode_write)
        else $error("mode written on read only frame");
    chk_mode_write: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && frame_end && !nowr_bit) |=> o_mode_write)
        else $error("mode write missing");
    chk_irq_raise: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && flag_fall && i_supply_fault_irq_enable) |=> o_supply_fault_irq)
        else $error("supply interrupt missing");
    chk_cause_hold: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (!i_reset_event || !i_ce) |=> $stable(reset_cause_field_reg))
        else $error("reset cause changed without event");
    chk_por_clear: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && i_normal_entered) |=> !power_up_reset_flag_reg)
        else $error("power-up flag not cleared");
endmodule
`default_nettype wire

// File: core/ssdr_pkg.sv
package ssdr_pkg;
    // ---------------------------------------------------------------
    // Frame layout
    // ---------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int SEL_HI = 15;
    localparam int SEL_LO = 14;
    localparam int RDSEL_POS = 13;
    localparam int NOWR_POS = 12;
    localparam logic [1:0] SEL_SYSTEM = 2'h0;
    localparam logic [4:0] BITCNT_LAST = 5'h0F;
    localparam logic [4:0] BITCNT_INIT = 5'h00;
    // ---------------------------------------------------------------
    // Diagnosis field positions
    // ---------------------------------------------------------------
    localparam int GND_POS = 11;
    localparam int CANF_HI = 10;
    localparam int CANF_LO = 7;
    localparam int LINF_HI = 6;
    localparam int LINF_LO = 5;
    localparam int AUX_POS = 4;
    localparam int CANREG_POS = 3;
    localparam int MCU_POS = 2;
    localparam int CAN_TRANSCEIVER_MODE_CODE_HI = 1;
    localparam int CAN_TRANSCEIVER_MODE_CODE_LO = 0;
    localparam logic [3:0] CANF_RESERVED = 4'hA;
    localparam logic [3:0] CANF_NONE = 4'h0;
    // ---------------------------------------------------------------
    // Status field positions and reset values
    // ---------------------------------------------------------------
    localparam int RSRC_HI = 11;
    localparam int RSRC_LO = 8;
    localparam int ENS_POS = 1;
    localparam int PWR_POS = 0;
    localparam logic [3:0] RSRC_POR = 4'h0;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [11:0] MODE_ZERO = 12'h000;
endpackage

// File: core/ssdr_frame_if.sv
`timescale 1ns/1ps
`default_nettype none
// Serial frame information passed from the shifter to the register bank, and the reply word back
interface ssdr_frame_if;
    logic [2:0] hdr;
    logic hdr_valid;
    logic done;
    logic [15:0] rx_word;
    logic [15:0] tx_word;
    modport shifter (output hdr, hdr_valid, done, rx_word, input tx_word);
    modport bank (input hdr, hdr_valid, done, rx_word, output tx_word);
endinterface
`default_nettype wire

// File: core/ssdr_shifter.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Serial frame shifter, sampled pins, MSB first
// ---------------------------------------------------------------
module ssdr_shifter
    import ssdr_pkg::*;
(
    // Clock and control
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Synchronised pins
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_mosi,
    // Outputs
    output logic o_miso,
    // Bank side
    ssdr_frame_if.shifter frm
);
    logic [4:0] cnt_reg;
    logic [15:0] rx_reg;
    logic [15:0] tx_reg;
    logic sck_d_reg;
    logic load_reg;
    logic miso_reg;
    wire rise = i_sck & ~sck_d_reg;
    wire fall = ~i_sck & sck_d_reg;
    wire active = ~i_cs_n;
    wire [15:0] rx_shift = {rx_reg[14:0], i_mosi};

    // Header known after the first three bits arrive
    assign frm.hdr = rx_reg[2:0];
    assign frm.hdr_valid = (cnt_reg == 5'h03);
    assign frm.rx_word = rx_reg;
    assign o_miso = miso_reg;

    // Capture on rising clock, launch next bit on falling clock
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= BITCNT_INIT;
            rx_reg <= WORD_ZERO;
            tx_reg <= WORD_ZERO;
            sck_d_reg <= 1'b0;
            load_reg <= 1'b0;
            miso_reg <= 1'b0;
            frm.done <= 1'b0;
        end else if (i_ce) begin
            sck_d_reg <= i_sck;
            frm.done <= 1'b0;
            if (!active) begin
                cnt_reg <= BITCNT_INIT;
                load_reg <= 1'b0;
            end else if (rise) begin
                rx_reg <= rx_shift;
                cnt_reg <= cnt_reg + 5'h01;
                frm.done <= (cnt_reg == BITCNT_LAST);
                if (cnt_reg == 5'h02) begin
                    load_reg <= 1'b1;
                end
            end else if (load_reg) begin
                // Header slots already passed on the wire, so bit 12 leads
                tx_reg <= {frm.tx_word[NOWR_POS:0], 3'h0};
                load_reg <= 1'b0;
            end else if (fall && cnt_reg >= 5'h03) begin
                miso_reg <= tx_reg[15];
                tx_reg <= {tx_reg[14:0], 1'b0};
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/ssdr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Host side serial master, clock idles low, MSB first
// ---------------------------------------------------------------
module ssdr_host_model #(
    parameter int HALF = 8
) (
    // Clock
    input wire logic i_mclk,
    // Serial pins
    output logic o_cs_n,
    output logic o_sck,
    output logic o_mosi,
    input wire logic i_miso
);
    // Pins idle with select high and clock low
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_mosi = 1'b0;
    end

    // One whole 16-bit frame; the half period stays well above the pin
    // synchroniser delay so every reply bit has settled before it is taken
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge i_mclk);
        o_cs_n <= 1'b0;
        repeat (HALF) @(posedge i_mclk);
        for (int i = 15; i >= 0; i--) begin
            o_mosi <= tx[i]; // Header bits lead the frame
            repeat (HALF) @(posedge i_mclk);
            rx[i] = i_miso; // Reply taken just before the rising edge
            o_sck <= 1'b1;
            repeat (HALF) @(posedge i_mclk);
            o_sck <= 1'b0;
        end
        repeat (HALF) @(posedge i_mclk);
        o_cs_n <= 1'b1;
        // Released data line shows the inverse, not a stale copy
        o_mosi <= ~tx[0];
        repeat (2 * HALF) @(posedge i_mclk);
    endtask
endmodule
`default_nettype wire

// File: dv/system_status_diagnosis_readback_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module system_status_diagnosis_readback_test;
    import ssdr_pkg::*;
    // ---------------------------------------------------------------
    // Signals and tables
    // ---------------------------------------------------------------
    logic clk, rst_n, ce, cs_n, sck, mosi, miso, mode_wr, irq;
    logic gnd, aux_off, canreg_off, canreg_on, mcu_uv, enable_pin_state_flag, norm, rst_ev, irq_en;
    logic [3:0] canf, cause;
    logic [1:0] linf, mode;
    logic [11:0] mode_data, exp_data;
    logic [15:0] rx;
    int fails, checked, cycles, n_wr, n_irq, exp_wr;
    // Rows {ground, can code, lin code, mode}: inputs and what reads back
    logic [8:0] rin [8] = '{9'h000, 9'h1FF, 9'h0AA, 9'h115, 9'h0EC, 9'h162, 9'h097, 9'h179};
    logic [8:0] rexp [8] = '{9'h000, 9'h1FF, 9'h00A, 9'h115, 9'h0EC, 9'h162, 9'h097, 9'h179};

    ssdr_top dut (.i_mclk(clk), .i_reset_n(rst_n), .i_ce(ce), .i_cs_n(cs_n), .i_sck(sck),
        .i_mosi(mosi), .o_miso(miso), .i_gnd_offset_out(gnd), .i_can_fault(canf), .i_lin_fault(linf),
        .i_aux_overload_off(aux_off), .i_canreg_overload_off(canreg_off), .i_canreg_restart(canreg_on),
        .i_mcu_undervolt(mcu_uv), .i_can_mode(mode), .i_enable_pin_high(enable_pin_state_flag), .i_normal_entered(norm),
        .i_reset_event(rst_ev), .i_reset_cause(cause), .i_supply_fault_irq_enable(irq_en),
        .o_mode_write(mode_wr), .o_mode_data(mode_data), .o_supply_fault_irq(irq));
    ssdr_host_model #(.HALF(8)) host (.i_mclk(clk), .o_cs_n(cs_n), .o_sck(sck), .o_mosi(mosi), .i_miso(miso));

    // ---------------------------------------------------------------
    // Clock, pulse counters and hang guard
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // A frame takes about 300 cycles; the ceiling is nearly four times the whole 18-frame run
    always @(posedge clk) begin
        cycles++;
        if (mode_wr === 1'b1) n_wr++;
        if (irq === 1'b1) n_irq++;
        if (cycles > 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [12:0] dg(input logic [8:0] f, input logic [2:0] regs);
        return {1'b0, f[8:2], regs, f[1:0]};
    endfunction
    function automatic logic [12:0] st(input logic [3:0] c, input logic e, input logic p);
        return {1'b0, c, 6'h00, e, p};
    endfunction
    // Reads one frame and checks reply, write pulse count and written data
    task automatic rd(input logic [15:0] tx, input logic [12:0] exp, input string nm);
        host.frame(tx, rx);
        `CHK(nm, exp, rx[12:0])
        repeat (4) @(posedge clk);
        if (tx[SEL_HI:SEL_LO] == SEL_SYSTEM && tx[NOWR_POS] == 1'b0) begin
            exp_wr++;
            exp_data = tx[11:0];
        end
        `CHK("write count", exp_wr, n_wr)
        `CHK("write data", exp_data, mode_data)
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        {gnd, canf, linf, mode, aux_off, canreg_off, canreg_on, mcu_uv} = 13'h0000;
        {norm, rst_ev, irq_en, cause, exp_data} = 19'h0_0000;
        enable_pin_state_flag = 1'b1;
        ce = 1'b1;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (30) @(posedge clk);
        `CHK("reset outputs", 15'h0000, {miso, mode_wr, mode_data, irq})
        rd(16'h1000, st(4'h0, 1'b1, 1'b1), "status after reset");
        rd(16'h3000, dg(9'h000, 3'h7), "diag after reset");
        // Table rows, alternating read-only and mode-writing frames
        for (int r = 0; r < 8; r++) begin
            @(posedge clk);
            {gnd, canf, linf, mode} <= rin[r];
            rd({3'h1, r[0], 9'h0A5, r[2:0]}, dg(rexp[r], 3'h7), "diag row");
        end
        @(posedge clk);
        {gnd, canf, linf, mode} <= 9'h000;
        // Reset cause captured only on an event; later cause changes ignored
        @(posedge clk);
        enable_pin_state_flag <= 1'b0;
        cause <= 4'hB;
        rst_ev <= 1'b1;
        @(posedge clk);
        rst_ev <= 1'b0;
        rd(16'h0123, st(4'hB, 1'b0, 1'b1), "status cause");
        @(posedge clk);
        cause <= 4'h3;
        rst_ev <= 1'b1;
        norm <= 1'b1;
        enable_pin_state_flag <= 1'b1;
        @(posedge clk);
        rst_ev <= 1'b0;
        norm <= 1'b0;
        cause <= 4'hF;
        rd(16'h1000, st(4'h3, 1'b1, 1'b0), "status normal");
        rd(16'h4FFF, 13'h0000, "other select");
        // Undervoltage latch with the interrupt still disabled
        @(posedge clk);
        mcu_uv <= 1'b1;
        @(posedge clk);
        mcu_uv <= 1'b0;
        rd(16'h3000, dg(9'h000, 3'h6), "mcu uv latched");
        rd(16'h3000, dg(9'h000, 3'h7), "mcu uv cleared");
        `CHK("irq while disabled", 0, n_irq)
        // Overloads with the interrupt enabled, then the CAN regulator restarts
        @(posedge clk);
        irq_en <= 1'b1;
        aux_off <= 1'b1;
        repeat (4) @(posedge clk);
        canreg_off <= 1'b1;
        @(posedge clk);
        canreg_off <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK("irq count", 2, n_irq)
        rd(16'h3000, dg(9'h000, 3'h1), "regulators off");
        @(posedge clk);
        canreg_on <= 1'b1;
        @(posedge clk);
        canreg_on <= 1'b0;
        rd(16'h3000, dg(9'h000, 3'h3), "can regulator back");
        // Enable low freezes the flags, so an undervoltage seen only then is lost
        @(posedge clk);
        ce <= 1'b0;
        mcu_uv <= 1'b1;
        repeat (4) @(posedge clk);
        mcu_uv <= 1'b0;
        ce <= 1'b1;
        rd(16'h3000, dg(9'h000, 3'h3), "frozen by enable");
        `CHK("irq while frozen", 2, n_irq)
        tally_and_finish();
    end
endmodule
`default_nettype wire
